// *** src/eag_regs.svh ***
/*
 file: opcode, postbyte and cycle constants of the address generator.
 assumes: included by bare name wherever these constants are needed.
*/
`ifndef EAG_REGS_SVH
`define EAG_REGS_SVH
`define EAG_PC_RESET 16'h0000
`define EAG_DP_RESET 8'h00
`define EAG_PTR_RESET 16'h0000
`define EAG_OP_PAGE2 8'h10
`define EAG_OP_PAGE3 8'h11
`define EAG_OP_TRAP 8'h3f
`define EAG_OP_WAIT 8'h3c
`define EAG_OP_RET 8'h3b
`define EAG_OP_SYNC 8'h13
`define EAG_PB_INC1 4'h0
`define EAG_PB_INC2 4'h1
`define EAG_PB_DEC1 4'h2
`define EAG_PB_DEC2 4'h3
`define EAG_PB_ZERO 4'h4
`define EAG_PB_SECOND_ACCUMULATOR 4'h5
`define EAG_PB_FIRST_ACCUMULATOR 4'h6
`define EAG_PB_OFF8 4'h8
`define EAG_PB_OFF16 4'h9
`define EAG_PB_ACCD 4'hb
`define EAG_PB_PC8 4'hc
`define EAG_PB_PC16 4'hd
`define EAG_PB_XIND 4'hf
`define EAG_CYC_IND 4'h3
`endif

// *** src/eag_pkg.sv ***
/*
 file: types of the address generator.
 assumes: nothing beyond a SystemVerilog compiler.
*/
package eag_pkg;
    typedef enum logic [3:0] {
        ST_IDLE, ST_DIVERT, ST_FETCH, ST_POST, ST_OFFH, ST_OFFL,
        ST_INDH, ST_INDL, ST_STALL, ST_DONE, ST_TRAP
    } eag_state_t;
    typedef enum logic [2:0] {M_INH, M_IMM, M_DIR, M_EXT, M_REG, M_IDX} eag_mode_t;
    typedef enum logic [2:0] {K_EXT, K_DIR, K_OFF8, K_OFF16, K_PC8, K_PC16, K_XIND} eag_kind_t;
    typedef enum logic [2:0] {
        T_NONE, T_SOFT1, T_SOFT2, T_SOFT3, T_WAIT, T_RET, T_SYNC
    } eag_trap_t;
endpackage

// *** src/eag_addr_gen.sv ***
/*
 file: fetch loop and effective address generator of an 8-bit processor.
 assumes: memory answers each byte read with MEM_ACK and MEM_RDATA;
 an execution unit consumes EA_VALID and drives accumulators and writes.
*/
`timescale 1ns/1ps
`include "eag_regs.svh"
// Summary of operation
// RULE1: after reset, fetch an instruction, then hand it over, forever.
// RULE2: software trap, wait, return and sync opcodes stop the loop until resumed.
// RULE3: interrupt, halt or bus request divert the loop at an instruction boundary.
// RULE4: inherent opcodes fetch no address bytes.
// RULE5: immediate operand sits right after opcode, one or two bytes.
// RULE6: extended: next two bytes, high first, are the address.
// RULE7: extended indirect: two bytes after postbyte point at the address.
// RULE8: direct: byte after opcode is low half, page base is high half.
// RULE9: reset clears the page base register.
// RULE10: register mode: byte after opcode selects registers.
// RULE11: postbyte bit 7 low: signed 5-bit offset added to pointer.
// RULE12: zero offset: address is pointer; indirect form adds three cycles.
// RULE13: constant offset uses a copy; pointer keeps its value.
// RULE14: code 8 fetches a signed byte offset; one cycle, one byte.
// RULE15: code 9 fetches a signed word offset; four cycles, two bytes.
// RULE16: codes 5 and 6 add second or first accumulator; sources unchanged.
// RULE17: accumulator offset adds one cycle, four when indirect.
// RULE18: codes c and d offset from program counter; select bits ignored.
// RULE19: select bits 6:5 pick first index, second index, user, hardware stack.
// RULE20: bit 7 and bit 4 set: read final address from computed address.
// RULE21: auto increment after use, auto decrement before use, by one or two.
// RULE22: unassigned postbyte codes are flagged invalid.
// RULE23: address arithmetic wraps modulo 65536 with sign-extended offsets.
module eag_addr_gen import eag_pkg::*; #(
    parameter logic [15:0] RESET_PC = `EAG_PC_RESET
) (
    input wire logic CLOCK,
    input wire logic RST_B,
    output logic MEM_REQ,
    output logic [15:0] MEM_ADDR,
    input wire logic MEM_ACK,
    input wire logic [7:0] MEM_RDATA,
    input wire logic IRQ_REQ,
    input wire logic HALT_REQ,
    input wire logic BUS_REQUEST_INPUT_B,
    input wire logic RESUME,
    input wire logic [7:0] FIRST_ACCUMULATOR,
    input wire logic [7:0] SECOND_ACCUMULATOR,
    input wire logic PTR_WR,
    input wire logic [1:0] PTR_SEL,
    input wire logic [15:0] PTR_WDATA,
    input wire logic PC_WR,
    input wire logic [15:0] PC_WDATA,
    input wire logic DP_WR,
    input wire logic [7:0] DP_WDATA,
    output logic EA_VALID,
    output logic [15:0] EA,
    output logic [2:0] MODE,
    output logic [7:0] OPCODE,
    output logic [1:0] PAGE,
    output logic [7:0] POSTBYTE,
    output logic IMM_WIDE,
    output logic INVALID,
    output logic TRAP_WAIT,
    output logic [2:0] TRAP_KIND,
    output logic DIVERTED,
    output logic [15:0] PC_OUT,
    output logic [7:0] DP_OUT,
    output logic [63:0] PTR_OUT
);
    eag_state_t state_reg, state_next;
    eag_mode_t mode_reg, mode_next;
    eag_kind_t kind_reg, kind_next;
    eag_trap_t trap_reg, trap_next;
    logic [15:0] ptr_reg [4];
    logic [15:0] ptr_next [4];
    logic [15:0] pc_reg, pc_next, ea_reg, ea_next, addr_reg, addr_next;
    logic [7:0] dp_reg, dp_next, op_reg, op_next, pb_reg, pb_next, hi_reg, hi_next;
    logic [1:0] page_reg, page_next;
    logic [3:0] cnt_reg, cnt_next;
    logic ind_reg, ind_next, bad_reg, bad_next, wide_reg, wide_next;
    logic [15:0] p, w;
    logic [3:0] code;
    logic bad;

    always_comb begin
        state_next = state_reg;
        mode_next = mode_reg;
        kind_next = kind_reg;
        trap_next = trap_reg;
        ptr_next = ptr_reg;
        pc_next = pc_reg;
        ea_next = ea_reg;
        dp_next = dp_reg;
        op_next = op_reg;
        pb_next = pb_reg;
        hi_next = hi_reg;
        page_next = page_reg;
        cnt_next = cnt_reg;
        ind_next = ind_reg;
        bad_next = bad_reg;
        wide_next = wide_reg;
        bad = 1'b0;
        code = MEM_RDATA[3:0];
        p = ptr_reg[pb_reg[6:5]];
        w = {hi_reg, MEM_RDATA};
        if (PTR_WR) begin
            ptr_next[PTR_SEL] = PTR_WDATA;
        end
        if (PC_WR) begin
            pc_next = PC_WDATA;
        end
        if (DP_WR) begin
            dp_next = DP_WDATA;
        end
        case (state_reg)
            ST_IDLE: begin
                if (IRQ_REQ || HALT_REQ || !BUS_REQUEST_INPUT_B) begin
                    state_next = ST_DIVERT; // RULE3
                end else begin
                    state_next = ST_FETCH; // RULE1
                    page_next = 2'h0;
                    trap_next = T_NONE;
                    bad_next = 1'b0;
                end
            end
            ST_DIVERT: begin
                if (!IRQ_REQ && !HALT_REQ && BUS_REQUEST_INPUT_B) begin
                    state_next = ST_IDLE; // RULE3
                end
            end
            ST_FETCH: begin
                if (MEM_ACK) begin
                    pc_next = pc_reg + 16'h0001;
                    if (page_reg == 2'h0 && (MEM_RDATA == `EAG_OP_PAGE2 ||
                            MEM_RDATA == `EAG_OP_PAGE3)) begin
                        page_next = MEM_RDATA[0] ? 2'h2 : 2'h1;
                    end else begin
                        op_next = MEM_RDATA;
                        mode_next = M_INH;
                        wide_next = 1'b0;
                        case (MEM_RDATA[7:4])
                            4'h0, 4'h9, 4'hd: mode_next = M_DIR;
                            4'h6, 4'ha, 4'he: mode_next = M_IDX;
                            4'h7, 4'hb, 4'hf: mode_next = M_EXT;
                            4'h8, 4'hc: begin
                                mode_next = M_IMM;
                                wide_next = page_reg != 2'h0 || code == 4'h3 ||
                                    code == 4'hc || code == 4'he;
                            end
                            4'h2: begin
                                mode_next = M_IMM;
                                wide_next = page_reg != 2'h0;
                            end
                            4'h1: begin
                                if (code == 4'he || code == 4'hf) begin
                                    mode_next = M_REG;
                                end else if (code == 4'ha || code == 4'hc) begin
                                    mode_next = M_IMM;
                                end else if (code == 4'h6 || code == 4'h7) begin
                                    mode_next = M_IMM;
                                    wide_next = 1'b1;
                                end
                            end
                            4'h3: begin
                                if (code < 4'h4) begin
                                    mode_next = M_IDX;
                                end else if (code < 4'h8) begin
                                    mode_next = M_REG;
                                end else if (code == 4'hc) begin
                                    mode_next = M_IMM;
                                end
                            end
                            default: mode_next = M_INH;
                        endcase
                        if (MEM_RDATA == `EAG_OP_TRAP) begin // RULE2
                            trap_next = page_reg == 2'h0 ? T_SOFT1 :
                                (page_reg == 2'h1 ? T_SOFT2 : T_SOFT3);
                        end else if (page_reg == 2'h0 && MEM_RDATA == `EAG_OP_WAIT) begin
                            trap_next = T_WAIT;
                        end else if (page_reg == 2'h0 && MEM_RDATA == `EAG_OP_RET) begin
                            trap_next = T_RET;
                        end else if (page_reg == 2'h0 && MEM_RDATA == `EAG_OP_SYNC) begin
                            trap_next = T_SYNC;
                        end
                        case (mode_next)
                            M_INH: begin
                                ea_next = 16'h0000; // RULE4
                                state_next = ST_DONE;
                            end
                            M_IMM: begin
                                ea_next = pc_reg + 16'h0001; // RULE5
                                pc_next = pc_reg + (wide_next ? 16'h0003 : 16'h0002);
                                state_next = ST_DONE;
                            end
                            M_DIR: begin
                                kind_next = K_DIR;
                                state_next = ST_OFFL;
                            end
                            M_EXT: begin
                                kind_next = K_EXT;
                                state_next = ST_OFFH;
                            end
                            default: state_next = ST_POST; // RULE10
                        endcase
                    end
                end
            end
            ST_POST: begin
                if (MEM_ACK) begin
                    pb_next = MEM_RDATA;
                    pc_next = pc_reg + 16'h0001;
                    p = ptr_reg[MEM_RDATA[6:5]]; // RULE19
                    ind_next = MEM_RDATA[7] & MEM_RDATA[4];
                    cnt_next = 4'h0;
                    state_next = ST_STALL;
                    if (mode_reg == M_REG) begin
                        ea_next = 16'h0000; // RULE10
                        state_next = ST_DONE;
                    end else if (!MEM_RDATA[7]) begin
                        ind_next = 1'b0;
                        ea_next = p + {{11{MEM_RDATA[4]}}, MEM_RDATA[4:0]}; // RULE11
                        cnt_next = 4'h1;
                    end else begin
                        case (code)
                            `EAG_PB_INC1, `EAG_PB_INC2: begin
                                ea_next = p; // RULE21
                                ptr_next[MEM_RDATA[6:5]] = p + {14'h0000, code[0], ~code[0]};
                                cnt_next = {3'h1, code[0]} - 4'h0;
                                bad = ind_next & ~code[0];
                            end
                            `EAG_PB_DEC1, `EAG_PB_DEC2: begin
                                ea_next = p - {14'h0000, code[0], ~code[0]}; // RULE21
                                ptr_next[MEM_RDATA[6:5]] = ea_next;
                                cnt_next = {3'h1, code[0]};
                                bad = ind_next & ~code[0];
                            end
                            `EAG_PB_ZERO: ea_next = p; // RULE12
                            `EAG_PB_SECOND_ACCUMULATOR, `EAG_PB_FIRST_ACCUMULATOR: begin
                                ea_next = p + {{8{(code[1] ? FIRST_ACCUMULATOR[7] :
                                    SECOND_ACCUMULATOR[7])}}, (code[1] ?
                                    FIRST_ACCUMULATOR : SECOND_ACCUMULATOR)}; // RULE16
                                cnt_next = 4'h1; // RULE17
                            end
                            `EAG_PB_ACCD: begin
                                ea_next = p + {FIRST_ACCUMULATOR, SECOND_ACCUMULATOR};
                                cnt_next = 4'h4;
                            end
                            `EAG_PB_OFF8, `EAG_PB_PC8: begin
                                kind_next = code[2] ? K_PC8 : K_OFF8; // RULE14 RULE18
                                cnt_next = 4'h1;
                                state_next = ST_OFFL;
                            end
                            `EAG_PB_OFF16, `EAG_PB_PC16: begin
                                kind_next = code[2] ? K_PC16 : K_OFF16; // RULE15 RULE18
                                cnt_next = code[2] ? 4'h5 : 4'h4;
                                state_next = ST_OFFH;
                            end
                            `EAG_PB_XIND: begin
                                kind_next = K_XIND; // RULE7
                                cnt_next = 4'h2;
                                bad = ~ind_next;
                                state_next = ST_OFFH;
                            end
                            default: bad = 1'b1; // RULE22
                        endcase
                        if (bad) begin
                            ptr_next = ptr_reg;
                            if (PTR_WR) begin
                                ptr_next[PTR_SEL] = PTR_WDATA;
                            end
                            ea_next = 16'h0000;
                            bad_next = 1'b1;
                            ind_next = 1'b0;
                            state_next = ST_DONE;
                        end else begin
                            if (ind_next) begin
                                cnt_next = cnt_next + `EAG_CYC_IND; // RULE12 RULE17
                            end
                            if (state_next == ST_STALL && ind_next) begin
                                state_next = ST_INDH; // RULE20
                            end
                        end
                    end
                end
            end
            ST_OFFH: begin
                if (MEM_ACK) begin
                    hi_next = MEM_RDATA; // RULE6
                    pc_next = pc_reg + 16'h0001;
                    state_next = ST_OFFL;
                end
            end
            ST_OFFL: begin
                if (MEM_ACK) begin
                    pc_next = pc_reg + 16'h0001;
                    state_next = ind_reg ? ST_INDH : ST_STALL;
                    case (kind_reg)
                        K_EXT: begin
                            ea_next = w; // RULE6
                            state_next = ST_DONE;
                        end
                        K_DIR: begin
                            ea_next = {dp_reg, MEM_RDATA}; // RULE8
                            state_next = ST_DONE;
                        end
                        K_OFF8: ea_next = p + {{8{MEM_RDATA[7]}}, MEM_RDATA}; // RULE23
                        K_OFF16: ea_next = p + w; // RULE13
                        K_PC8: ea_next = pc_next + {{8{MEM_RDATA[7]}}, MEM_RDATA};
                        K_PC16: ea_next = pc_next + w;
                        default: ea_next = w; // RULE7
                    endcase
                end
            end
            ST_INDH: begin
                if (MEM_ACK) begin
                    hi_next = MEM_RDATA;
                    state_next = ST_INDL;
                end
            end
            ST_INDL: begin
                if (MEM_ACK) begin
                    ea_next = w; // RULE20
                    state_next = ST_STALL;
                end
            end
            ST_STALL: begin
                if (cnt_reg == 4'h0) begin
                    state_next = ST_DONE;
                end else begin
                    cnt_next = cnt_reg - 4'h1;
                end
            end
            ST_DONE: state_next = trap_reg != T_NONE ? ST_TRAP : ST_IDLE; // RULE2
            ST_TRAP: begin
                if (RESUME) begin
                    state_next = ST_IDLE;
                end
            end
            default: state_next = ST_IDLE;
        endcase
        case (state_next)
            ST_INDH: addr_next = ea_next;
            ST_INDL: addr_next = ea_reg + 16'h0001;
            default: addr_next = pc_next;
        endcase
    end

    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            state_reg <= ST_IDLE;
            mode_reg <= M_INH;
            kind_reg <= K_EXT;
            trap_reg <= T_NONE;
            ptr_reg <= '{default: `EAG_PTR_RESET};
            pc_reg <= RESET_PC;
            ea_reg <= 16'h0000;
            addr_reg <= RESET_PC;
            dp_reg <= `EAG_DP_RESET; // RULE9
            op_reg <= 8'h00;
            pb_reg <= 8'h00;
            hi_reg <= 8'h00;
            page_reg <= 2'h0;
            cnt_reg <= 4'h0;
            ind_reg <= 1'b0;
            bad_reg <= 1'b0;
            wide_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            mode_reg <= mode_next;
            kind_reg <= kind_next;
            trap_reg <= trap_next;
            ptr_reg <= ptr_next;
            pc_reg <= pc_next;
            ea_reg <= ea_next;
            addr_reg <= addr_next;
            dp_reg <= dp_next;
            op_reg <= op_next;
            pb_reg <= pb_next;
            hi_reg <= hi_next;
            page_reg <= page_next;
            cnt_reg <= cnt_next;
            ind_reg <= ind_next;
            bad_reg <= bad_next;
            wide_reg <= wide_next;
        end
    end

    assign MEM_REQ = state_reg inside {ST_FETCH, ST_POST, ST_OFFH, ST_OFFL, ST_INDH, ST_INDL};
    assign MEM_ADDR = addr_reg;
    assign EA_VALID = state_reg == ST_DONE;
    assign EA = ea_reg;
    assign MODE = mode_reg;
    assign OPCODE = op_reg;
    assign PAGE = page_reg;
    assign POSTBYTE = pb_reg;
    assign IMM_WIDE = wide_reg;
    assign INVALID = bad_reg;
    assign TRAP_WAIT = state_reg == ST_TRAP;
    assign TRAP_KIND = trap_reg;
    assign DIVERTED = state_reg == ST_DIVERT;
    assign PC_OUT = pc_reg;
    assign DP_OUT = dp_reg;
    assign PTR_OUT = {ptr_reg[3], ptr_reg[2], ptr_reg[1], ptr_reg[0]};

    logic up_reg;
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            up_reg <= 1'b0;
        end else begin
            up_reg <= 1'b1;
        end
    end
    logic post_ack;
    assign post_ack = state_reg == ST_POST && MEM_ACK && mode_reg == M_IDX && !PTR_WR;

    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RST_B);

    property p_dp_reset;
        !up_reg |-> dp_reg == 8'h00;
    endproperty
    a_dp_reset: assert property (p_dp_reset) else $error("page base not cleared"); // RULE9
    property p_direct;
        state_reg == ST_OFFL && MEM_ACK && kind_reg == K_DIR && !DP_WR
            |=> EA_VALID && EA == {$past(dp_reg), $past(MEM_RDATA)};
    endproperty
    a_direct: assert property (p_direct) else $error("direct address wrong"); // RULE8
    property p_ext;
        state_reg == ST_OFFL && MEM_ACK && kind_reg == K_EXT
            |=> EA_VALID && EA == {$past(hi_reg), $past(MEM_RDATA)};
    endproperty
    a_ext: assert property (p_ext) else $error("extended address wrong"); // RULE6
    property p_inh;
        EA_VALID && mode_reg == M_INH |-> $past(state_reg) == ST_FETCH && EA == 16'h0000;
    endproperty
    a_inh: assert property (p_inh) else $error("inherent fetched bytes"); // RULE4
    property p_off5;
        post_ack && !MEM_RDATA[7] |=> ea_reg == $past(ptr_reg[MEM_RDATA[6:5]])
            + {{11{$past(MEM_RDATA[4])}}, $past(MEM_RDATA[4:0])}
            && ptr_reg[$past(MEM_RDATA[6:5])] == $past(ptr_reg[MEM_RDATA[6:5]]);
    endproperty
    a_off5: assert property (p_off5) else $error("5-bit offset wrong"); // RULE11
    property p_inc1;
        post_ack && MEM_RDATA[7:4] inside {4'h8, 4'ha, 4'hc, 4'he} && code == 4'h0
            |=> ptr_reg[$past(MEM_RDATA[6:5])] == $past(ptr_reg[MEM_RDATA[6:5]]) + 16'h0001;
    endproperty
    a_inc1: assert property (p_inc1) else $error("post increment wrong"); // RULE21
    property p_zero;
        post_ack && MEM_RDATA[7] && MEM_RDATA[4:0] == 5'h04
            |=> ea_reg == $past(ptr_reg[MEM_RDATA[6:5]]) ##1 EA_VALID;
    endproperty
    a_zero: assert property (p_zero) else $error("zero offset wrong"); // RULE12
    property p_off8;
        post_ack && MEM_RDATA[7] && MEM_RDATA[4:0] == 5'h08
            |=> state_reg == ST_OFFL && cnt_reg == 4'h1;
    endproperty
    a_off8: assert property (p_off8) else $error("8-bit offset setup wrong"); // RULE14
    property p_bad;
        post_ack && MEM_RDATA[7] && code == 4'h7 |=> INVALID && EA_VALID;
    endproperty
    a_bad: assert property (p_bad) else $error("invalid code accepted"); // RULE22
    property p_trap;
        state_reg == ST_FETCH && MEM_ACK && page_reg == 2'h0 && MEM_RDATA == 8'h3f
            |=> EA_VALID ##1 TRAP_WAIT && TRAP_KIND == 3'(T_SOFT1);
    endproperty
    a_trap: assert property (p_trap) else $error("trap not taken"); // RULE2
    c_ind: cover property (state_reg == ST_INDL && MEM_ACK);
    c_div: cover property (DIVERTED ##1 !DIVERTED);
    c_pc16: cover property (EA_VALID && kind_reg == K_PC16);
endmodule

// *** test/eag_mem_model.sv ***
/* memory partner: answers byte reads from an array, promptly or slowly.
 assumes: a read request stands until MEM_ACK; answers land on the falling edge. */
`timescale 1ns/1ps
module eag_mem_model (
    input wire logic CLOCK,
    input wire logic SLOW,
    input wire logic MEM_REQ,
    input wire logic [15:0] MEM_ADDR,
    output logic MEM_ACK = 1'b0,
    output logic [7:0] MEM_RDATA = 8'h00
);
    logic [7:0] mem [0:65535];
    int waited = 0;
    // data toggles outside an answer, so no stale byte can be mistaken for one
    always @(negedge CLOCK) begin
        MEM_ACK <= 1'b0;
        MEM_RDATA <= ~MEM_RDATA;
        waited <= 0;
        if (!MEM_ACK && MEM_REQ === 1'b1 && waited >= (SLOW ? 2 : 0)) begin
            MEM_ACK <= 1'b1;
            MEM_RDATA <= mem[MEM_ADDR];
        end else if (!MEM_ACK && MEM_REQ === 1'b1) waited <= waited + 1;
    end
endmodule

// *** test/testbench.sv ***
/* bench: runs a short program of inherent, immediate, direct, extended and most indexed forms through the generator.
 assumes: memory partner holds the program; reset pc is zero. */
`timescale 1ns/1ps
module testbench import eag_pkg::*; ();
    logic CLOCK = 1'b0, RST_B = 1'b0, HALT_REQ = 1'b1, PTR_WR = 1'b0, DP_WR = 1'b0;
    logic SLOW = 1'b0, MEM_REQ, MEM_ACK, EA_VALID, INVALID, TRAP_WAIT, DIVERTED;
    logic IRQ_REQ = 1'b0, RESUME = 1'b0, IMM_WIDE;
    logic [1:0] PAGE;
    logic [7:0] OPCODE, POSTBYTE;
    logic [15:0] PC_OUT;
    logic [1:0] PTR_SEL = 2'h0;
    logic [2:0] MODE, TRAP_KIND;
    logic [7:0] acc_a = 8'h00, acc_b = 8'h00, DP_WDATA = 8'h00, MEM_RDATA, DP_OUT;
    logic [15:0] PTR_WDATA = 16'h0000, p = 16'h0000, MEM_ADDR, EA;
    logic [15:0] ptr [4];
    logic [63:0] PTR_OUT;
    logic [19:0] notes [$];
    int n_errors = 0, samples_checked = 0, cycles = 0;
    integer seed = 32'h3e80;
    eag_addr_gen eag_addr_gen_inst (.CLOCK(CLOCK), .RST_B(RST_B), .MEM_REQ(MEM_REQ),
        .MEM_ADDR(MEM_ADDR), .MEM_ACK(MEM_ACK), .MEM_RDATA(MEM_RDATA), .IRQ_REQ(IRQ_REQ),
        .HALT_REQ(HALT_REQ), .BUS_REQUEST_INPUT_B(1'b1), .RESUME(RESUME),
        .FIRST_ACCUMULATOR(acc_a), .SECOND_ACCUMULATOR(acc_b), .PTR_WR(PTR_WR),
        .PTR_SEL(PTR_SEL), .PTR_WDATA(PTR_WDATA), .PC_WR(1'b0), .PC_WDATA(16'h0000),
        .DP_WR(DP_WR), .DP_WDATA(DP_WDATA), .EA_VALID(EA_VALID), .EA(EA), .MODE(MODE),
        .OPCODE(OPCODE), .PAGE(PAGE), .POSTBYTE(POSTBYTE), .IMM_WIDE(IMM_WIDE),
        .INVALID(INVALID), .TRAP_WAIT(TRAP_WAIT), .TRAP_KIND(TRAP_KIND),
        .DIVERTED(DIVERTED), .PC_OUT(PC_OUT), .DP_OUT(DP_OUT), .PTR_OUT(PTR_OUT));
    eag_mem_model eag_mem_model_inst (.CLOCK(CLOCK), .SLOW(SLOW), .MEM_REQ(MEM_REQ),
        .MEM_ADDR(MEM_ADDR), .MEM_ACK(MEM_ACK), .MEM_RDATA(MEM_RDATA));
    always #4 CLOCK = ~CLOCK;
    task automatic conclude();
        if (n_errors == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // loads one instruction at p and notes its decoded result
    task automatic ins(input int n, input logic [31:0] b, input eag_mode_t m,
        input logic inv, input logic [15:0] ea);
        for (int i = 0; i < n; i++) begin
            eag_mem_model_inst.mem[p] = b[31-8*i -: 8];
            p++;
        end
        notes.push_back({m, inv, ea});
    endtask
    task automatic idx(input logic [7:0] pb, input logic [15:0] ea);
        ins(2, {8'ha6, pb, 16'h0000}, M_IDX, 1'b0, ea);
    endtask
    always @(negedge CLOCK) begin
        cycles++;
        if (cycles > 3000) begin
            n_errors++;
            conclude();
        end
        if (EA_VALID === 1'b1) begin
            SLOW <= 1'($random(seed));
            if (notes.size() == 0) cmp(64'h1, 64'h0);
            else cmp({MODE, INVALID, EA}, notes.pop_front());
        end
    end
    initial begin
        for (int i = 0; i < 4; i++) ptr[i] = {1'b1, 15'($random(seed))};
        acc_a = 8'($random(seed));
        acc_b = 8'($random(seed));
        repeat (5) @(negedge CLOCK);
        RST_B = 1'b1;
        repeat (3) @(negedge CLOCK);
        cmp(DP_OUT, 8'h00);
        cmp({DIVERTED, MEM_REQ}, 2'b10);
        PTR_WR = 1'b1;
        for (int i = 0; i < 4; i++) begin
            PTR_SEL = 2'(i);
            PTR_WDATA = ptr[i];
            @(negedge CLOCK);
        end
        PTR_WR = 1'b0;
        DP_WR = 1'b1;
        DP_WDATA = 8'($random(seed));
        @(negedge CLOCK);
        DP_WR = 1'b0;
        ins(1, 32'h4f000000, M_INH, 1'b0, 16'h0000);
        ins(2, 32'h86200000, M_IMM, 1'b0, p + 16'h1);
        ins(2, 32'h965a0000, M_DIR, 1'b0, {DP_WDATA, 8'h5a});
        ins(3, 32'hb6c0de00, M_EXT, 1'b0, 16'hc0de);
        idx(8'h10, ptr[0] - 16'h10);
        idx(8'h6f, ptr[3] + 16'hf);
        idx(8'hc4, ptr[2]);
        idx(8'ha5, ptr[1] + {{8{acc_b[7]}}, acc_b});
        idx(8'h86, ptr[0] + {{8{acc_a[7]}}, acc_a});
        ins(3, 32'ha6888000, M_IDX, 1'b0, ptr[0] - 16'h80);
        ins(4, 32'ha6c97fff, M_IDX, 1'b0, ptr[2] + 16'h7fff);
        ins(3, 32'ha6ec7f00, M_IDX, 1'b0, p + 16'h3 + 16'h7f);
        eag_mem_model_inst.mem[ptr[1]] = 8'h3c;
        eag_mem_model_inst.mem[ptr[1] + 16'h1] = 8'h9a;
        idx(8'hb4, 16'h3c9a);
        eag_mem_model_inst.mem[16'h4000] = 8'h71;
        eag_mem_model_inst.mem[16'h4001] = 8'he5;
        ins(4, 32'ha69f4000, M_IDX, 1'b0, 16'h71e5);
        ins(2, 32'ha6870000, M_IDX, 1'b1, 16'h0000);
        idx(8'h80, ptr[0]);
        idx(8'hc3, ptr[2] - 16'h2);
        ins(1, 32'h13000000, M_INH, 1'b0, 16'h0000);
        ins(1, 32'h3f000000, M_INH, 1'b0, 16'h0000);
        HALT_REQ = 1'b0;
        for (int i = 0; i < 2000 && TRAP_WAIT !== 1'b1; i++) @(negedge CLOCK);
        cmp({TRAP_WAIT, TRAP_KIND}, {1'b1, T_SYNC});
        {IRQ_REQ, RESUME} = 2'b11;
        repeat (2) begin
            @(negedge CLOCK);
            RESUME = 1'b0;
        end
        cmp({DIVERTED, MEM_REQ}, 2'b10);
        IRQ_REQ = 1'b0;
        for (int i = 0; i < 2000 && TRAP_WAIT !== 1'b1; i++) @(negedge CLOCK);
        cmp({TRAP_WAIT, TRAP_KIND}, {1'b1, T_SOFT1});
        cmp(notes.size(), 0);
        cmp({PC_OUT, PAGE, POSTBYTE, OPCODE, IMM_WIDE}, {p, 2'h0, 8'hc3, 8'h3f, 1'b0});
        cmp(PTR_OUT, {ptr[3], ptr[2] - 16'h2, ptr[1], ptr[0] + 16'h1});
        conclude();
    end
endmodule
